// [rtl/ams_pkg.sv]
// Package: constants and types for the ADC input sequencer
package ams_pkg;

  // Register byte offsets
  localparam logic [7:0] AMS_CTRL_OFS   = 8'h00;
  localparam logic [7:0] AMS_NSEL0_OFS  = 8'h04;
  localparam logic [7:0] AMS_NSEL1_OFS  = 8'h08;
  localparam logic [7:0] AMS_ASEL0_OFS  = 8'h0C;
  localparam logic [7:0] AMS_ASEL1_OFS  = 8'h10;
  localparam logic [7:0] AMS_ACCUM_OFS  = 8'h14;
  localparam logic [7:0] AMS_STATUS_OFS = 8'h18;

  // Control register field positions
  localparam int AMS_SPF_LSB   = 0;
  localparam int AMS_FIR_LSB   = 4;
  localparam int AMS_CHOP_LSB  = 6;
  localparam int AMS_ALT_BIT   = 8;
  localparam int AMS_BATEN_BIT = 9;
  localparam int AMS_EQSEL_LSB = 10;
  localparam int AMS_DIFF_LSB  = 12;
  localparam int AMS_ICHOP_BIT = 16;

  // Slot count limits and table size
  localparam int         AMS_NUM_SLOTS = 10;
  localparam logic [3:0] AMS_SPF_MIN   = 4'h1;
  localparam logic [3:0] AMS_SPF_MAX   = 4'hA;

  // Signal numbers
  localparam logic [3:0] AMS_SIG_PHA_CURR = 4'h0;
  localparam logic [3:0] AMS_SIG_PHA_VOLT = 4'h1;
  localparam logic [3:0] AMS_SIG_TEMP = 4'hA;
  localparam logic [3:0] AMS_SIG_VBAT = 4'hB;

  // Chop modes
  localparam logic [1:0] AMS_CHOP_AUTO = 2'h0;
  localparam logic [1:0] AMS_CHOP_LOW  = 2'h1;
  localparam logic [1:0] AMS_CHOP_HIGH = 2'h2;
  localparam logic [1:0] AMS_CHOP_TOGG = 2'h3;

  // Reset values
  localparam logic [31:0] AMS_CTRL_RST  = 32'h0000_0007;
  localparam logic [39:0] AMS_NSEL_RST  = 40'h00_0654_3210;
  localparam logic [39:0] AMS_ASEL_RST  = 40'h00_0654_3B1A;
  localparam logic [15:0] AMS_ACCUM_RST = 16'h0002;

  // Sequencer states, gray along idle, slot, sync
  typedef enum logic [1:0]
  {
    AMS_ST_IDLE = 2'b00,
    AMS_ST_SLOT = 2'b01,
    AMS_ST_SYNC = 2'b11
  } ams_state_t;

endpackage

// [rtl/ams_alt_capture.sv]
// Alternate frame request edge capture with pending flag
`timescale 1ns/100ps
module ams_alt_capture
(
  // Clock and reset
  input  wire logic mclk_in,
  input  wire logic rst_n_in,
  // Request and consume
  input  wire logic req_in,
  input  wire logic consume_in,
  // Held request
  output logic      pending_out
);
  logic req_prev_q;
  logic req_prev_d;
  logic pending_q;
  logic pending_d;

  always_comb
  begin
    req_prev_d = req_in;
    pending_d  = (req_in & ~req_prev_q) | (pending_q & ~consume_in);
  end

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      req_prev_q <= 1'b0;
      pending_q  <= 1'b0;
    end
    else
    begin
      req_prev_q <= req_prev_d;
      pending_q  <= pending_d;
    end
  end

  assign pending_out = pending_q;
endmodule

// [rtl/ams_sequencer.sv]
// ADC input multiplexer sequencer with APB registers
//
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/100ps
module ams_sequencer
  import ams_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        resetn_in,
  // Slow clock, synchronous level
  input  wire logic        slow_tick_clock_in,
  // APB slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  input  wire logic [3:0]  pstrb_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // Multiplexer and converter
  output logic      [3:0]  mux_select_out,
  output logic             mux_advance_out,
  output logic             conv_start_out,
  output logic             reference_swap_out,
  output logic             battery_measure_enable_out,
  output logic      [3:0]  current_diff_out,
  output logic      [3:0]  return_to_neg_out,
  // Compute engine
  output logic             frame_sync_pulse_out,
  output logic             ce_start_out,
  output logic             result_store_out,
  output logic      [3:0]  result_addr_out
);

  // Reset release
  logic rst_s1_q;
  logic rst_n_q;

  always_ff @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  function automatic logic [3:0] pick_sel(input logic [39:0] tbl, input logic [3:0] idx);
    logic [5:0] base;
    base = {idx, 2'b00};
    return tbl[base +: 4];
  endfunction

  function automatic logic [31:0] merge32(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        r[8*i +: 8] = wd[8*i +: 8];
    end
    return r;
  endfunction

  // Register state
  logic [31:0] ctrl_q;
  logic [31:0] ctrl_d;
  logic [39:0] nsel_q;
  logic [39:0] nsel_d;
  logic [39:0] asel_q;
  logic [39:0] asel_d;
  logic [15:0] accum_q;
  logic [15:0] accum_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic        slverr_q;
  logic        slverr_d;

  // Sequencer state
  ams_state_t  state_q;
  ams_state_t  state_d;
  logic [3:0]  slot_q;
  logic [3:0]  slot_d;
  logic [1:0]  cyc_q;
  logic [1:0]  cyc_d;
  logic        alt_q;
  logic        alt_d;
  logic [15:0] fcnt_q;
  logic [15:0] fcnt_d;
  logic        swap_q;
  logic        swap_d;
  logic        ret_q;
  logic        ret_d;
  logic        tick_prev_q;
  logic [3:0]  sel_q;
  logic [3:0]  sel_d;
  logic        adv_q;
  logic        adv_d;
  logic        conv_q;
  logic        conv_d;
  logic        sync_q;
  logic        sync_d;
  logic        ce_q;
  logic        ce_d;
  logic        store_q;
  logic        store_d;
  logic [3:0]  raddr_q;
  logic [3:0]  raddr_d;

  logic        tick;
  logic        alt_pending;
  logic        consume;
  logic [3:0]  spf;
  logic [1:0]  fir_last;
  logic [1:0]  chop;
  logic        bat_en;
  logic [15:0] accum_last;
  logic        forced_alt;
  logic [3:0]  next_sel;
  logic [31:0] accum_wr;

  assign tick       = slow_tick_clock_in & ~tick_prev_q;
  assign chop       = ctrl_q[AMS_CHOP_LSB +: 2];
  assign bat_en     = ctrl_q[AMS_BATEN_BIT];
  assign accum_last = (accum_q == 16'h0000) ? 16'h0000 : accum_q - 16'h0001;
  // forced alternate in auto mode on last frame of interval
  assign forced_alt = (chop == AMS_CHOP_AUTO) && (fcnt_q == accum_last);

  always_comb
  begin
    spf = ctrl_q[AMS_SPF_LSB +: 4];
    if (spf < AMS_SPF_MIN)
      spf = AMS_SPF_MIN;
    else if (spf > AMS_SPF_MAX)
      spf = AMS_SPF_MAX;
    fir_last = (ctrl_q[AMS_FIR_LSB +: 2] > 2'h2) ? 2'h2 : ctrl_q[AMS_FIR_LSB +: 2];
  end

  ams_alt_capture u_alt
  (
    .mclk_in     (mclk_in),
    .rst_n_in    (rst_n_q),
    .req_in      (ctrl_q[AMS_ALT_BIT]),
    .consume_in  (consume),
    .pending_out (alt_pending)
  );

  // APB register access
  logic wr_en;
  logic rd_en;
  assign wr_en = psel_in & penable_in & pwrite_in;
  assign rd_en = psel_in & penable_in & ~pwrite_in;
  assign accum_wr = merge32({16'h0000, accum_q}, pwdata_in, pstrb_in);

  always_comb
  begin
    ctrl_d   = ctrl_q;
    nsel_d   = nsel_q;
    asel_d   = asel_q;
    accum_d  = accum_q;
    prdata_d = 32'h0000_0000;
    slverr_d = 1'b0;
    if (psel_in & ~penable_in)
    begin
      case (paddr_in)
        AMS_CTRL_OFS:   prdata_d = {15'h0000, ctrl_q[16:0]};
        AMS_NSEL0_OFS:  prdata_d = nsel_q[31:0];
        AMS_NSEL1_OFS:  prdata_d = {24'h00_0000, nsel_q[39:32]};
        AMS_ASEL0_OFS:  prdata_d = asel_q[31:0];
        AMS_ASEL1_OFS:  prdata_d = {24'h00_0000, asel_q[39:32]};
        AMS_ACCUM_OFS:  prdata_d = {16'h0000, accum_q};
        AMS_STATUS_OFS: prdata_d = {fcnt_q, 7'h00, ret_q, sync_q, alt_pending,
                                    swap_q, alt_q, slot_q};
        default:        slverr_d = 1'b1;
      endcase
      if (pwrite_in)
        prdata_d = 32'h0000_0000;
      if (pwrite_in && paddr_in == AMS_STATUS_OFS)
        slverr_d = 1'b1;
    end
    if (wr_en)
    begin
      case (paddr_in)
        AMS_CTRL_OFS:  ctrl_d  = merge32(ctrl_q, pwdata_in, pstrb_in) & 32'h0001_FFFF;
        AMS_NSEL0_OFS: nsel_d[31:0]  = merge32(nsel_q[31:0], pwdata_in, pstrb_in);
        AMS_NSEL1_OFS: nsel_d[39:32] = pstrb_in[0] ? pwdata_in[7:0] : nsel_q[39:32];
        AMS_ASEL0_OFS: asel_d[31:0]  = merge32(asel_q[31:0], pwdata_in, pstrb_in);
        AMS_ASEL1_OFS: asel_d[39:32] = pstrb_in[0] ? pwdata_in[7:0] : asel_q[39:32];
        AMS_ACCUM_OFS: accum_d = (accum_wr[15:0] == 16'h0000) ? accum_q : accum_wr[15:0];
        default:       ;
      endcase
    end
    if (rd_en)
    begin
      prdata_d = prdata_q;
      slverr_d = slverr_q;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      ctrl_q   <= AMS_CTRL_RST;
      nsel_q   <= AMS_NSEL_RST;
      asel_q   <= AMS_ASEL_RST;
      accum_q  <= AMS_ACCUM_RST;
      prdata_q <= 32'h0000_0000;
      slverr_q <= 1'b0;
    end
    else
    begin
      ctrl_q   <= ctrl_d;
      nsel_q   <= nsel_d;
      asel_q   <= asel_d;
      accum_q  <= accum_d;
      prdata_q <= prdata_d;
      slverr_q <= slverr_d;
    end
  end

  assign pready_out  = 1'b1;
  assign prdata_out  = rd_en ? prdata_q : 32'h0000_0000;
  assign pslverr_out = psel_in & penable_in & slverr_q;

  // Frame sequencer
  always_comb
  begin
    state_d  = state_q;
    slot_d   = slot_q;
    cyc_d    = cyc_q;
    alt_d    = alt_q;
    fcnt_d   = fcnt_q;
    swap_d   = swap_q;
    ret_d    = ret_q;
    sel_d    = sel_q;
    adv_d    = 1'b0;
    conv_d   = 1'b0;
    sync_d   = sync_q;
    ce_d     = 1'b0;
    store_d  = 1'b0;
    raddr_d  = raddr_q;
    consume  = 1'b0;
    next_sel = 4'h0;
    if (tick)
    begin
      case (state_q)
        AMS_ST_IDLE, AMS_ST_SYNC:
        begin
          // new frame, take pending or forced alternate
          consume  = 1'b1;
          alt_d    = alt_pending | forced_alt;
          next_sel = (alt_pending | forced_alt) ? pick_sel(asel_q, 4'h0)
                                                : pick_sel(nsel_q, 4'h0);
          state_d  = AMS_ST_SLOT;
          slot_d   = 4'h0;
          cyc_d    = 2'h0;
          sync_d   = 1'b0;
          sel_d    = next_sel;
          adv_d    = 1'b1;
          conv_d   = (next_sel != AMS_SIG_VBAT) | bat_en;
        end
        AMS_ST_SLOT:
        begin
          if (cyc_q != fir_last)
            cyc_d = cyc_q + 2'h1;
          else
          begin
            store_d = (sel_q != AMS_SIG_VBAT) | bat_en;
            raddr_d = sel_q;
            cyc_d   = 2'h0;
            if (slot_q + 4'h1 >= spf)
            begin
              // sync cycle, swap update, engine launch
              state_d = AMS_ST_SYNC;
              sync_d  = 1'b1;
              ce_d    = 1'b1;
              fcnt_d  = (fcnt_q >= accum_last) ? 16'h0000 : fcnt_q + 16'h0001;
              ret_d   = ~ret_q;
              case (chop)
                AMS_CHOP_LOW:  swap_d = 1'b0;
                AMS_CHOP_HIGH: swap_d = 1'b1;
                AMS_CHOP_TOGG: swap_d = ~swap_q;
                default:       swap_d = (fcnt_d == accum_last) ? swap_q : ~swap_q;
              endcase
            end
            else
            begin
              slot_d   = slot_q + 4'h1;
              next_sel = alt_q ? pick_sel(asel_q, slot_q + 4'h1)
                               : pick_sel(nsel_q, slot_q + 4'h1);
              sel_d    = next_sel;
              adv_d    = 1'b1;
              conv_d   = (next_sel != AMS_SIG_VBAT) | bat_en;
            end
          end
        end
        default:
          state_d = AMS_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      state_q     <= AMS_ST_IDLE;
      slot_q      <= 4'h0;
      cyc_q       <= 2'h0;
      alt_q       <= 1'b0;
      fcnt_q      <= 16'h0000;
      swap_q      <= 1'b0;
      ret_q       <= 1'b0;
      tick_prev_q <= 1'b0;
      sel_q       <= AMS_SIG_PHA_CURR;
      adv_q       <= 1'b0;
      conv_q      <= 1'b0;
      sync_q      <= 1'b0;
      ce_q        <= 1'b0;
      store_q     <= 1'b0;
      raddr_q     <= 4'h0;
    end
    else
    begin
      state_q     <= state_d;
      slot_q      <= slot_d;
      cyc_q       <= cyc_d;
      alt_q       <= alt_d;
      fcnt_q      <= fcnt_d;
      swap_q      <= swap_d;
      ret_q       <= ret_d;
      tick_prev_q <= slow_tick_clock_in;
      sel_q       <= sel_d;
      adv_q       <= adv_d;
      conv_q      <= conv_d;
      sync_q      <= sync_d;
      ce_q        <= ce_d;
      store_q     <= store_d;
      raddr_q     <= raddr_d;
    end
  end

  // per pair mode; chopped return only in differential
  logic [3:0] diff;
  assign diff = ctrl_q[AMS_DIFF_LSB +: 4];

  assign mux_select_out             = sel_q;
  assign mux_advance_out            = adv_q;
  assign conv_start_out             = conv_q;
  assign reference_swap_out         = swap_q;
  assign battery_measure_enable_out = bat_en;
  assign current_diff_out           = diff;
  assign return_to_neg_out          = diff & {4{ctrl_q[AMS_ICHOP_BIT] & ret_q}};
  assign frame_sync_pulse_out       = sync_q;
  assign ce_start_out               = ce_q;
  assign result_store_out           = store_q;
  assign result_addr_out            = raddr_q;
endmodule

// [tb/ams_sequencer_chk.sv]
// Concurrent checks on the sequencer ports
`timescale 1ns/100ps
module ams_sequencer_chk
  import ams_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk_in,
  input  wire logic       resetn_in,
  // Bus
  input  wire logic       psel_in,
  input  wire logic       penable_in,
  input  wire logic [7:0] paddr_in,
  input  wire logic       pslverr_out,
  // Sequencer outputs
  input  wire logic [3:0] mux_select_out,
  input  wire logic       mux_advance_out,
  input  wire logic       conv_start_out,
  input  wire logic       reference_swap_out,
  input  wire logic       battery_measure_enable_out,
  input  wire logic [3:0] current_diff_out,
  input  wire logic [3:0] return_to_neg_out,
  input  wire logic       frame_sync_pulse_out,
  input  wire logic       ce_start_out
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!resetn_in);

  sequence s_sync_enter;
    $rose(frame_sync_pulse_out);
  endsequence

  sequence s_slot_start;
    mux_advance_out;
  endsequence

  sequence s_plain_start;
    mux_advance_out && mux_select_out != AMS_SIG_VBAT;
  endsequence

  sequence s_conv_allowed;
    battery_measure_enable_out || mux_select_out != AMS_SIG_VBAT;
  endsequence

  sequence s_slot_quiet;
    !mux_advance_out && !conv_start_out;
  endsequence

  sequence s_bad_access;
    psel_in && penable_in && paddr_in > AMS_STATUS_OFS;
  endsequence

  chk_engine_launch: assert property (s_sync_enter |-> ##[0:1] ce_start_out)
    else $error("engine start missing at frame sync");
  chk_launch_in_sync: assert property (ce_start_out |-> ##[0:1] frame_sync_pulse_out)
    else $error("engine start outside frame sync");
  chk_sync_hold: assert property (s_sync_enter |-> frame_sync_pulse_out[*8])
    else $error("frame sync too short");
  chk_sync_quiet: assert property (frame_sync_pulse_out |-> s_slot_quiet)
    else $error("slot activity during frame sync");
  chk_advance_pulse: assert property (s_slot_start |=> !mux_advance_out)
    else $error("advance longer than one cycle");
  chk_advance_conv: assert property (s_plain_start |-> ##[0:1] conv_start_out)
    else $error("conversion start missing at slot start");
  chk_battery_gate: assert property (conv_start_out |-> s_conv_allowed)
    else $error("battery converted while disabled");
  chk_select_hold: assert property ($changed(mux_select_out) |-> mux_advance_out)
    else $error("selection changed inside a slot");
  chk_swap_moment: assert property ($changed(reference_swap_out) |-> s_sync_enter)
    else $error("swap changed outside sync entry");
  chk_return_diff: assert property ((return_to_neg_out & ~current_diff_out) == 4'h0)
    else $error("return swap on single ended pair");
  chk_bad_addr: assert property (s_bad_access |-> pslverr_out)
    else $error("unmapped access without error");
endmodule

// [tb/ams_adc_model.sv]
// Converter side model that checks result store addresses
`timescale 1ns/100ps
module ams_adc_model
  import ams_pkg::*;
(
  // Clock
  input  wire logic       mclk_in,
  // From the sequencer
  input  wire logic [3:0] mux_select_in,
  input  wire logic       conv_start_in,
  input  wire logic       result_store_in,
  input  wire logic [3:0] result_addr_in,
  // Tallies
  output int              stores_out,
  output int              addr_err_out
);
  logic [3:0] held_q = 4'h0;
  logic       busy_q = 1'b0;
  initial stores_out = 0;
  initial addr_err_out = 0;
  always @(negedge mclk_in)
  begin
    if (result_store_in)
    begin
      stores_out++;
      if (!busy_q || result_addr_in !== held_q)
        addr_err_out++;
      busy_q <= 1'b0;
    end
    if (conv_start_in)
    begin
      held_q <= mux_select_in;
      busy_q <= 1'b1;
    end
  end
endmodule

// [tb/ams_sequencer_tb.sv]
// Self-checking bench for the input sequencer
`timescale 1ns/100ps
module ams_sequencer_tb;
  import ams_pkg::*;
  localparam logic [39:0] NTBL = 40'hB7_5A43_2106;
  logic        mclk_in = 1'b0;
  logic        resetn_in = 1'b0;
  logic        slow = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  sel;
  logic        adv;
  logic        conv;
  logic        swap;
  logic [3:0]  diff;
  logic [3:0]  ret;
  logic        sync;
  logic        sync_d = 1'b0;
  logic        store;
  logic [3:0]  addr;
  logic [3:0]  cur_q[$];
  logic [3:0]  snap_q[$];
  int          cyc = 0;
  int          tick_cnt = 0;
  int          conv_n = 0;
  int          snap_conv = 0;
  int          last_sync = 0;
  int          snap_len = 0;
  int          frames = 0;
  int          stores;
  int          addr_err;
  int          checks = 0;
  int          bad_count = 0;

  ams_sequencer u_dut (.mclk_in(mclk_in), .resetn_in(resetn_in), .slow_tick_clock_in(slow),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .pstrb_in(4'hF), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .mux_select_out(sel), .mux_advance_out(adv), .conv_start_out(conv),
    .reference_swap_out(swap), .battery_measure_enable_out(), .current_diff_out(diff),
    .return_to_neg_out(ret), .frame_sync_pulse_out(sync), .ce_start_out(),
    .result_store_out(store), .result_addr_out(addr));

  ams_adc_model u_adc (.mclk_in(mclk_in), .mux_select_in(sel), .conv_start_in(conv),
    .result_store_in(store), .result_addr_in(addr), .stores_out(stores),
    .addr_err_out(addr_err));

  always #50 mclk_in = ~mclk_in;

  // Slow tick every 306 cycles, near 32768 Hz
  always @(posedge mclk_in)
  begin
    tick_cnt <= (tick_cnt == 305) ? 0 : tick_cnt + 1;
    slow <= (tick_cnt < 153);
    cyc <= cyc + 1;
    if (cyc == 95000)
    begin
      bad_count++;
      tally_and_finish();
    end
  end

  // Frame snapshot at each sync rise, sampled off the launch edge
  always @(negedge mclk_in)
  begin
    sync_d <= sync;
    if (adv)
      cur_q.push_back(sel);
    if (conv)
      conv_n++;
    if (sync && !sync_d)
    begin
      snap_q = cur_q;
      cur_q = {};
      snap_conv = conv_n;
      conv_n = 0;
      snap_len = cyc - last_sync;
      last_sync = cyc;
      frames++;
    end
  end

  task tally_and_finish();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    int   n;
    logic rdy;
    @(posedge mclk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_in);
    penable <= 1'b1;
    n = 0;
    do
    begin
      // Answer taken as it stands for the sampling edge
      @(negedge mclk_in);
      rdy = pready;
      r = prdata;
      e = pslverr;
      @(posedge mclk_in);
      n++;
    end
    while (rdy !== 1'b1 && n < 16);
    if (rdy !== 1'b1)
      bad_count++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task wait_sync();
    int f;
    int n;
    f = frames;
    n = 0;
    while (frames == f && n < 13000)
    begin
      @(negedge mclk_in);
      n++;
    end
    check("frame seen", {31'h0, frames != f}, 32'h1);
  endtask

  function automatic logic [31:0] ctrl(int spf, int fir, int chop, logic [31:0] ex);
    return 32'(spf) | 32'(fir) << AMS_FIR_LSB | 32'(chop) << AMS_CHOP_LSB | ex;
  endfunction

  task t_reset();
    logic [31:0] r;
    logic        e;
    apb(1'b0, AMS_CTRL_OFS, 32'h0, r, e);
    check("ctrl reset", r, AMS_CTRL_RST);
    apb(1'b0, AMS_NSEL0_OFS, 32'h0, r, e);
    check("normal table reset", r, AMS_NSEL_RST[31:0]);
    apb(1'b0, AMS_ASEL0_OFS, 32'h0, r, e);
    check("alt table reset", r, AMS_ASEL_RST[31:0]);
    apb(1'b0, 8'h1C, 32'h0, r, e);
    check("unmapped error", {31'h0, e}, 32'h1);
    check("unmapped data", r, 32'h0);
    apb(1'b1, AMS_STATUS_OFS, 32'hFFFF_FFFF, r, e);
    check("status write error", {31'h0, e}, 32'h1);
  endtask

  task t_frame(input int spf, input int fir);
    wr(AMS_NSEL0_OFS, NTBL[31:0]);
    wr(AMS_NSEL1_OFS, {24'h0, NTBL[39:32]});
    wr(AMS_CTRL_OFS, ctrl(spf, fir, 1, 32'h0));
    wait_sync();
    wait_sync();
    wait_sync();
    check("frame length", snap_len, 32'((spf * (fir + 1) + 1) * 306));
    check("slot count", snap_q.size(), 32'(spf));
    for (int i = 0; i < spf; i++)
      check("slot select", {28'h0, snap_q[i]}, {28'h0, NTBL[4*i+:4]});
    check("conversions", snap_conv, 32'(spf - (spf == 10)));
  endtask

  task t_alt(input logic b);
    logic [31:0] base;
    base = ctrl(7, 0, 1, 32'(b) << AMS_BATEN_BIT);
    // voltages in the same slots as the alternate table
    wr(AMS_NSEL0_OFS, AMS_NSEL_RST[31:0]);
    wr(AMS_NSEL1_OFS, {24'h0, AMS_NSEL_RST[39:32]});
    wr(AMS_CTRL_OFS, base);
    wait_sync();
    wait_sync();
    wr(AMS_CTRL_OFS, base | 32'h1 << AMS_ALT_BIT);
    wr(AMS_CTRL_OFS, base);
    wait_sync();
    for (int i = 0; i < 7; i++)
      check("alt select", {28'h0, snap_q[i]}, {28'h0, AMS_ASEL_RST[4*i+:4]});
    check("alt conversions", snap_conv, b ? 32'h7 : 32'h6);
    wait_sync();
    for (int i = 0; i < 7; i++)
      check("back to normal", {28'h0, snap_q[i]}, {28'h0, AMS_NSEL_RST[4*i+:4]});
  endtask

  task t_auto();
    logic [3:0] f_prev;
    logic       s_prev;
    wr(AMS_CTRL_OFS, ctrl(1, 0, 0, 32'h0));
    wait_sync();
    wait_sync();
    f_prev = snap_q[0];
    s_prev = swap;
    for (int i = 0; i < 4; i++)
    begin
      wait_sync();
      check("forced alt order", {28'h0, f_prev ^ snap_q[0]}, {28'h0, AMS_SIG_TEMP});
      check("auto swap", {31'h0, swap ^ s_prev}, {31'h0, snap_q[0] == AMS_SIG_TEMP});
      f_prev = snap_q[0];
      s_prev = swap;
    end
  endtask

  task t_chop();
    logic       s0;
    logic       exp;
    logic [3:0] r0;
    for (int m = 1; m < 4; m++)
    begin
      wr(AMS_CTRL_OFS, ctrl(1, 0, m, 32'h0001_5000));
      wait_sync();
      wait_sync();
      s0 = swap;
      r0 = ret;
      wait_sync();
      exp = (m == 1) ? 1'b0 : (m == 2) ? 1'b1 : ~s0;
      check("swap", {31'h0, swap}, {31'h0, exp});
      check("diff pairs", {28'h0, diff}, 32'h5);
      check("return side", {28'h0, ret ^ r0}, 32'h5);
    end
  endtask

  initial
  begin
    repeat (4) @(posedge mclk_in);
    resetn_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    t_reset();
    t_frame(1, 0);
    t_frame(3, 1);
    t_frame(10, 1);
    t_frame(6, 0);
    t_alt(1'b0);
    t_alt(1'b1);
    t_chop();
    t_auto();
    check("store faults", addr_err, 32'h0);
    check("stores seen", {31'h0, stores != 0}, 32'h1);
    tally_and_finish();
  end
endmodule

bind ams_sequencer ams_sequencer_chk u_chk (.mclk_in(mclk_in), .resetn_in(resetn_in),
  .psel_in(psel_in), .penable_in(penable_in), .paddr_in(paddr_in), .pslverr_out(pslverr_out),
  .mux_select_out(mux_select_out), .mux_advance_out(mux_advance_out),
  .conv_start_out(conv_start_out), .reference_swap_out(reference_swap_out),
  .battery_measure_enable_out(battery_measure_enable_out),
  .current_diff_out(current_diff_out), .return_to_neg_out(return_to_neg_out),
  .frame_sync_pulse_out(frame_sync_pulse_out), .ce_start_out(ce_start_out));
